// *** common/amd_pkg.sv ***
// Package for the addressing-mode decoder: modes, mode count, address bounds, states, carrier types
package amd_pkg;

  // Addressing modes, seventeen in all
  typedef enum logic [4:0] {
    AMD_INH       = 5'h00, // Opcode alone
    AMD_IMM       = 5'h01, // Operand byte follows
    AMD_DIR_S     = 5'h02, // One address byte
    AMD_DIR_L     = 5'h03, // Two address bytes
    AMD_IDX_0     = 5'h04, // Index alone
    AMD_IDX_S     = 5'h05, // Byte offset plus index
    AMD_IDX_L     = 5'h06, // Word offset plus index
    AMD_IND_S     = 5'h07, // Byte pointer
    AMD_IND_L     = 5'h08, // Word pointer
    AMD_INDX_S    = 5'h09, // Byte pointer plus index
    AMD_INDX_L    = 5'h0A, // Word pointer plus index
    AMD_REL_D     = 5'h0B, // Offset follows
    AMD_REL_I     = 5'h0C, // Offset in page zero
    AMD_BIT_D     = 5'h0D, // Bit, direct
    AMD_BIT_I     = 5'h0E, // Bit, indirect
    AMD_BITR_D    = 5'h0F, // Bit test, direct, relative
    AMD_BITR_I    = 5'h10  // Bit test, indirect, relative
  } amd_mode_t;

  // Count of modes
  localparam logic [4:0]  AMD_MODE_COUNT = 5'h11;
  // Page zero upper bound
  localparam logic [15:0] AMD_PAGE0_MAX  = 16'h00FF;
  // Short indexed upper bound
  localparam logic [15:0] AMD_SIDX_MAX   = 16'h01FE;
  // Reset value of address outputs
  localparam logic [15:0] AMD_ADDR_RST   = 16'h0000;

  // Decoder states, each code one bit from the one listed before it
  typedef enum logic [2:0] {
    AMD_ST_IDLE = 3'b000, // Wait for an opcode
    AMD_ST_OP1  = 3'b001, // Take first operand byte
    AMD_ST_OP2  = 3'b011, // Take second operand byte
    AMD_ST_PTRH = 3'b010, // Read pointer high or byte
    AMD_ST_PTRL = 3'b110, // Read pointer low
    AMD_ST_DONE = 3'b111  // Present result
  } amd_state_t;

  // Request from the sequencer
  typedef struct packed {
    logic      start;  // Opcode decoded, begin
    amd_mode_t mode;   // Selected mode
    logic      use_y;  // Second index register
    logic      rmw;    // Read-modify-write instruction
    logic [7:0] idx_x; // First index value
    logic [7:0] idx_y; // Second index value
  } amd_req_t;

  // Result to the sequencer
  typedef struct packed {
    logic       done;     // Address ready pulse
    logic       illegal;  // Mode refused for this instruction
    logic [1:0] len;      // Operand bytes after opcode
    logic [15:0] ea;      // Effective address
    logic [7:0] imm;      // Immediate or relative byte
  } amd_res_t;

endpackage

// *** design/amd_decoder.sv ***
// Addressing-mode decoder and effective-address generator
`timescale 1ns/100ps
module amd_decoder
  import amd_pkg::*;
(
  input  wire logic       i_sys_clk,    // CPU clock
  input  wire logic       i_rstn,       // Reset, active low
  input  wire amd_req_t   i_req,        // Request from sequencer
  input  wire logic       i_byte_vld,   // Instruction byte present
  input  wire logic [7:0] i_byte,       // Instruction byte
  input  wire logic       i_mem_vld,    // Memory read data present
  input  wire logic [7:0] i_mem_data,   // Memory read data
  output logic            o_byte_req,   // Request next instruction byte
  output logic            o_mem_rd,     // Pointer read strobe
  output logic [15:0]     o_mem_addr,   // Pointer read address
  output logic            o_busy,       // Decode in progress
  output amd_res_t        o_res         // Result
);

  // Reset synchroniser
  logic rst_s1_r;   // First stage
  logic rst_s2_r;   // Released reset
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rstn = rst_s2_r; // Internal reset

  // Unsigned 16-bit sum of a base and an 8-bit index, carry kept
  function automatic logic [15:0] amd_add(input logic [15:0] base, input logic [7:0] idx);
    amd_add = base + {8'h00, idx};
  endfunction

  // Mode table
  logic [1:0] tbl_len;   // Bytes after opcode
  logic       tbl_short; // Short form
  amd_len_rom u_len_rom (
    .i_mode  (i_req.mode),
    .o_len   (tbl_len),
    .o_short (tbl_short)
  );

  // State and working registers
  amd_state_t  st_r,     st_nxt;     // Sequencer state
  amd_mode_t   mode_r,   mode_nxt;   // Latched mode
  logic [7:0]  idx_r,    idx_nxt;    // Selected index value
  logic [1:0]  len_r,    len_nxt;    // Latched length
  logic [15:0] opnd_r,   opnd_nxt;   // Operand bytes, high first
  logic [15:0] ptr_r,    ptr_nxt;    // Fetched pointer
  logic        breq_r,   breq_nxt;   // Byte request out
  logic        mrd_r,    mrd_nxt;    // Memory read out
  logic [15:0] maddr_r,  maddr_nxt;  // Memory address out
  logic        busy_r,   busy_nxt;   // Busy out
  amd_res_t    res_r,    res_nxt;    // Result out

  // Pointer-based modes
  function automatic logic amd_is_ind(input amd_mode_t m);
    amd_is_ind = (m == AMD_IND_S) || (m == AMD_IND_L) || (m == AMD_INDX_S) || (m == AMD_INDX_L) ||
                 (m == AMD_REL_I) || (m == AMD_BIT_I) || (m == AMD_BITR_I);
  endfunction

  // Word pointer modes
  function automatic logic amd_is_wptr(input amd_mode_t m);
    amd_is_wptr = (m == AMD_IND_L) || (m == AMD_INDX_L);
  endfunction

  // Effective address from latched operands
  function automatic logic [15:0] amd_ea(input amd_mode_t m, input logic [15:0] opnd,
                                         input logic [15:0] ptr, input logic [7:0] idx);
    case (m)
      AMD_DIR_S, AMD_BIT_D, AMD_BITR_D: amd_ea = {8'h00, opnd[7:0]};
      AMD_DIR_L:  amd_ea = opnd;
      AMD_IDX_0:  amd_ea = {8'h00, idx};
      AMD_IDX_S:  amd_ea = amd_add({8'h00, opnd[7:0]}, idx);
      AMD_IDX_L:  amd_ea = amd_add(opnd, idx);
      AMD_IND_S, AMD_BIT_I, AMD_BITR_I: amd_ea = {8'h00, ptr[7:0]};
      AMD_IND_L:  amd_ea = ptr;
      AMD_INDX_S: amd_ea = amd_add({8'h00, ptr[7:0]}, idx);
      AMD_INDX_L: amd_ea = amd_add(ptr, idx);
      default:    amd_ea = AMD_ADDR_RST;
    endcase
  endfunction

  // Next-state logic
  always_comb begin
    st_nxt    = st_r;
    mode_nxt  = mode_r;
    idx_nxt   = idx_r;
    len_nxt   = len_r;
    opnd_nxt  = opnd_r;
    ptr_nxt   = ptr_r;
    breq_nxt  = 1'b0;
    mrd_nxt   = 1'b0;
    maddr_nxt = maddr_r;
    busy_nxt  = busy_r;
    res_nxt   = res_r;
    res_nxt.done    = 1'b0;
    res_nxt.illegal = 1'b0;
    case (st_r)
      AMD_ST_IDLE: begin
        if (i_req.start) begin
          if (i_req.rmw && !tbl_short) begin
            // Long form refused for read-modify-write
            res_nxt.illegal = 1'b1;
            res_nxt.done    = 1'b1;
          end else begin
            mode_nxt = i_req.mode;
            idx_nxt  = i_req.use_y ? i_req.idx_y : i_req.idx_x;
            len_nxt  = tbl_len;
            opnd_nxt = AMD_ADDR_RST;
            ptr_nxt  = AMD_ADDR_RST;
            busy_nxt = 1'b1;
            if (tbl_len == 2'h0) begin
              st_nxt = AMD_ST_DONE;
            end else begin
              st_nxt   = AMD_ST_OP1;
              breq_nxt = 1'b1;
            end
          end
        end
      end
      AMD_ST_OP1: begin
        breq_nxt = 1'b1;
        if (i_byte_vld) begin
          opnd_nxt = {8'h00, i_byte};
          if (len_r == 2'h2) begin
            st_nxt = AMD_ST_OP2;
          end else if (amd_is_ind(mode_r)) begin
            breq_nxt  = 1'b0;
            mrd_nxt   = 1'b1;
            maddr_nxt = {8'h00, i_byte};
            st_nxt    = AMD_ST_PTRH;
          end else begin
            breq_nxt = 1'b0;
            st_nxt   = AMD_ST_DONE;
          end
        end
      end
      AMD_ST_OP2: begin
        breq_nxt = 1'b1;
        if (i_byte_vld) begin
          // High byte came first
          opnd_nxt = {opnd_r[7:0], i_byte};
          breq_nxt = 1'b0;
          st_nxt   = AMD_ST_DONE;
        end
      end
      AMD_ST_PTRH: begin
        mrd_nxt = 1'b1;
        if (i_mem_vld) begin
          if (amd_is_wptr(mode_r)) begin
            // Word pointer: high byte, then next address
            ptr_nxt   = {i_mem_data, 8'h00};
            maddr_nxt = maddr_r + 16'h0001;
            st_nxt    = AMD_ST_PTRL;
          end else begin
            ptr_nxt = {8'h00, i_mem_data};
            mrd_nxt = 1'b0;
            st_nxt  = AMD_ST_DONE;
          end
        end
      end
      AMD_ST_PTRL: begin
        mrd_nxt = 1'b1;
        if (i_mem_vld) begin
          ptr_nxt = {ptr_r[15:8], i_mem_data};
          mrd_nxt = 1'b0;
          st_nxt  = AMD_ST_DONE;
        end
      end
      AMD_ST_DONE: begin
        res_nxt.done = 1'b1;
        res_nxt.len  = len_r;
        res_nxt.ea   = amd_ea(mode_r, opnd_r, ptr_r, idx_r);
        res_nxt.imm  = opnd_r[7:0];
        busy_nxt     = 1'b0;
        st_nxt       = AMD_ST_IDLE;
      end
      default: begin
        st_nxt   = AMD_ST_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r    <= AMD_ST_IDLE;
      mode_r  <= AMD_INH;
      idx_r   <= 8'h00;
      len_r   <= 2'h0;
      opnd_r  <= AMD_ADDR_RST;
      ptr_r   <= AMD_ADDR_RST;
      breq_r  <= 1'b0;
      mrd_r   <= 1'b0;
      maddr_r <= AMD_ADDR_RST;
      busy_r  <= 1'b0;
      res_r   <= '0;
    end else begin
      st_r    <= st_nxt;
      mode_r  <= mode_nxt;
      idx_r   <= idx_nxt;
      len_r   <= len_nxt;
      opnd_r  <= opnd_nxt;
      ptr_r   <= ptr_nxt;
      breq_r  <= breq_nxt;
      mrd_r   <= mrd_nxt;
      maddr_r <= maddr_nxt;
      busy_r  <= busy_nxt;
      res_r   <= res_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign o_byte_req = breq_r;
  assign o_mem_rd   = mrd_r;
  assign o_mem_addr = maddr_r;
  assign o_busy     = busy_r;
  assign o_res      = res_r;

  // Modes outside the table are never latched
  chk_mode_range: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    mode_r < AMD_MODE_COUNT) else $error("mode out of range");

  // Short direct, short indirect and index alone land in page zero
  chk_short_page: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_DONE && (mode_r == AMD_DIR_S || mode_r == AMD_IND_S || mode_r == AMD_IDX_0))
    |=> o_res.ea <= AMD_PAGE0_MAX) else $error("short address left page zero");

  // Long direct keeps the full word
  chk_long_dir: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_DONE && mode_r == AMD_DIR_L) |=> o_res.ea == $past(opnd_r)) else $error("long direct wrong");

  // Long forms refused for read-modify-write
  chk_rmw_refuse: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_IDLE && i_req.start && i_req.rmw && !tbl_short)
    |=> o_res.illegal && o_res.done && !o_busy) else $error("long rmw not refused");

  // Refused request starts no fetch of any kind
  chk_rmw_nofetch: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_IDLE && i_req.start && i_req.rmw && !tbl_short)
    |=> !o_byte_req && !o_mem_rd) else $error("refused rmw fetched");

  // Inherent mode finishes without fetching
  chk_inh_len: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_IDLE && i_req.start && i_req.mode == AMD_INH && !i_req.rmw)
    |=> !o_byte_req ##1 o_res.done && o_res.len == 2'h0) else $error("inherent fetched bytes");

  // Immediate passes its operand byte
  chk_imm_byte: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_DONE && mode_r == AMD_IMM) |=> o_res.imm == $past(opnd_r[7:0]) && o_res.len == 2'h1)
    else $error("immediate byte wrong");

  // Index alone gives a page zero address
  chk_idx0_value: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_DONE && mode_r == AMD_IDX_0) |=> o_res.ea == {8'h00, $past(idx_r)})
    else $error("index alone wrong");

  // Short indexed sum reaches at most 1FE
  chk_sidx_max: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_DONE && (mode_r == AMD_IDX_S || mode_r == AMD_INDX_S))
    |=> o_res.ea <= AMD_SIDX_MAX && o_res.ea[15:9] == 7'h00) else $error("short indexed over 1FE");

  // Long indexed adds the whole offset word
  chk_long_idx: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_DONE && mode_r == AMD_IDX_L) |=> o_res.ea == $past(opnd_r) + {8'h00, $past(idx_r)})
    else $error("long indexed wrong");

  // Short indexed carry is kept
  chk_sidx_carry: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_DONE && mode_r == AMD_IDX_S)
    |=> o_res.ea == {8'h00, $past(opnd_r[7:0])} + {8'h00, $past(idx_r)}) else $error("short indexed wrapped");

  // Pointer read follows the address byte
  chk_ptr_read: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_OP1 && i_byte_vld && len_r == 2'h1 && amd_is_ind(mode_r))
    |=> o_mem_rd && o_mem_addr == {8'h00, $past(i_byte)}) else $error("pointer read missing");

  // Word pointer low byte read from the next address
  chk_word_ptr: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_PTRH && i_mem_vld && amd_is_wptr(mode_r))
    |=> o_mem_rd && o_mem_addr == $past(o_mem_addr) + 16'h0001) else $error("word pointer low read wrong");

  // Long indirect uses the fetched word as is
  chk_long_ind: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_DONE && mode_r == AMD_IND_L) |=> o_res.ea == $past(ptr_r))
    else $error("long indirect wrong");

  // Long indirect indexed adds index to the fetched word
  chk_indx_sum: assert property (@(posedge i_sys_clk) disable iff (!rstn)
    (st_r == AMD_ST_DONE && mode_r == AMD_INDX_L) |=> o_res.ea == $past(ptr_r) + {8'h00, $past(idx_r)})
    else $error("indirect indexed wrong");

endmodule

// *** design/amd_len_rom.sv ***
// Operand length and short-form table for each addressing mode
`timescale 1ns/100ps
module amd_len_rom
  import amd_pkg::*;
(
  input  wire amd_mode_t  i_mode,   // Mode to look up
  output logic [1:0]      o_len,    // Bytes after the opcode
  output logic            o_short   // Form is allowed for read-modify-write
);

  // Table lookup
  always_comb begin
    o_len   = 2'h0;
    o_short = 1'b0;
    case (i_mode)
      AMD_INH:    begin o_len = 2'h0; o_short = 1'b1; end
      AMD_IMM:    begin o_len = 2'h1; o_short = 1'b0; end
      AMD_DIR_S:  begin o_len = 2'h1; o_short = 1'b1; end
      AMD_DIR_L:  begin o_len = 2'h2; o_short = 1'b0; end
      AMD_IDX_0:  begin o_len = 2'h0; o_short = 1'b1; end
      AMD_IDX_S:  begin o_len = 2'h1; o_short = 1'b1; end
      AMD_IDX_L:  begin o_len = 2'h2; o_short = 1'b0; end
      AMD_IND_S:  begin o_len = 2'h1; o_short = 1'b1; end
      AMD_IND_L:  begin o_len = 2'h1; o_short = 1'b0; end
      AMD_INDX_S: begin o_len = 2'h1; o_short = 1'b1; end
      AMD_INDX_L: begin o_len = 2'h1; o_short = 1'b0; end
      AMD_REL_D:  begin o_len = 2'h1; o_short = 1'b0; end
      AMD_REL_I:  begin o_len = 2'h1; o_short = 1'b0; end
      AMD_BIT_D:  begin o_len = 2'h1; o_short = 1'b1; end
      AMD_BIT_I:  begin o_len = 2'h1; o_short = 1'b1; end
      AMD_BITR_D: begin o_len = 2'h1; o_short = 1'b1; end
      AMD_BITR_I: begin o_len = 2'h1; o_short = 1'b1; end
      default:    begin o_len = 2'h0; o_short = 1'b0; end
    endcase
  end

endmodule

// *** test/amd_mem_model.sv ***
// Program and data memory model feeding operand bytes and pointer reads
`timescale 1ns/100ps
module amd_mem_model (
  input  wire logic       i_sys_clk,   // CPU clock
  input  wire logic       i_slow,      // Insert wait cycles
  input  wire logic       i_byte_req,  // Decoder wants a byte
  output logic            o_byte_vld,  // Operand byte present
  output logic [7:0]      o_byte,      // Operand byte
  input  wire logic       i_mem_rd,    // Pointer read strobe
  input  wire logic [15:0] i_mem_addr, // Pointer read address
  output logic            o_mem_vld,   // Read data present
  output logic [7:0]      o_mem_data   // Read data
);
  logic [7:0] ops[$];        // Instruction stream, filled by the bench
  logic [7:0] zp[0:511];     // Page zero and just above
  logic [3:0] tick;          // Stall pattern
  logic       tb_b;          // Byte taken at this edge
  logic       tb_m;          // Read data taken at this edge

  initial begin
    o_byte_vld = 1'b0;
    o_byte     = 8'hA5;
    o_mem_vld  = 1'b0;
    o_mem_data = 8'h5A;
    tick       = 4'h0;
  end

  // Answer just after each edge; hold until taken, scramble when released
  always @(posedge i_sys_clk) begin
    tb_b = o_byte_vld && i_byte_req;
    tb_m = o_mem_vld && i_mem_rd;
    if (tb_b) void'(ops.pop_front());
    tick = tick + 4'h1;
    #1;
    if (o_byte_vld && !tb_b) o_byte_vld = 1'b1;
    else if (i_byte_req && ops.size() > 0 && !(i_slow && tick[0])) begin
      o_byte_vld = 1'b1;
      o_byte     = ops[0];
    end else begin
      o_byte_vld = 1'b0;
      o_byte     = ~o_byte;
    end
    if (o_mem_vld && !tb_m) o_mem_vld = 1'b1;
    else if (i_mem_rd && !(i_slow && tick[1])) begin
      o_mem_vld  = 1'b1;
      o_mem_data = zp[i_mem_addr[8:0]];
    end else begin
      o_mem_vld  = 1'b0;
      o_mem_data = ~o_mem_data;
    end
  end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the addressing-mode decoder
`timescale 1ns/100ps
module tb;
  import amd_pkg::*;
  // Expected result with masks for fields that apply
  typedef struct packed {
    logic        ill;
    logic [1:0]  len;
    logic [15:0] ea;
    logic [7:0]  imm;
    logic        ce;
    logic        ci;
  } amd_exp_t;

  logic       i_sys_clk, i_rstn, slow, bvld, mvld, byte_req, mem_rd, busy;
  logic [7:0] bdat, mdat;
  logic [15:0] maddr;
  amd_req_t   req;
  amd_res_t   res;
  amd_exp_t   expq[$];
  int         miscompares = 0;
  int         tests_run = 0;
  int         seed = 90083;

  amd_decoder dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_req(req), .i_byte_vld(bvld),
    .i_byte(bdat), .i_mem_vld(mvld), .i_mem_data(mdat), .o_byte_req(byte_req),
    .o_mem_rd(mem_rd), .o_mem_addr(maddr), .o_busy(busy), .o_res(res));
  amd_mem_model mem_i (.i_sys_clk(i_sys_clk), .i_slow(slow), .i_byte_req(byte_req),
    .o_byte_vld(bvld), .o_byte(bdat), .i_mem_rd(mem_rd), .i_mem_addr(maddr),
    .o_mem_vld(mvld), .o_mem_data(mdat));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Operand bytes after the opcode
  function automatic logic [1:0] len_of(input amd_mode_t m);
    case (m)
      AMD_INH, AMD_IDX_0: return 2'h0;
      AMD_DIR_L, AMD_IDX_L: return 2'h2;
      default: return 2'h1;
    endcase
  endfunction

  // Long forms refused for read-modify-write
  function automatic logic refused(input amd_mode_t m);
    return m inside {AMD_IMM, AMD_DIR_L, AMD_IDX_L, AMD_IND_L, AMD_INDX_L, AMD_REL_D, AMD_REL_I};
  endfunction

  // One decode: note the expectation, feed bytes, start, wait for done
  task automatic run_op(input amd_mode_t m, input logic y, input logic rmw, input logic [7:0] x,
                        input logic [7:0] yv, input logic [7:0] b0, input logic [7:0] b1);
    amd_exp_t    e;
    logic [7:0]  ix;
    logic [15:0] w, p;
    int          n;
    ix = y ? yv : x;
    w = {b0, b1};
    p = {mem_i.zp[9'(b0)], mem_i.zp[9'(b0) + 9'h1]};
    e = '0;
    e.len = len_of(m);
    e.ce = 1'b1;
    case (m)
      AMD_INH: e.ce = 1'b0;
      AMD_IMM, AMD_REL_D, AMD_REL_I: begin
        e.ce = 1'b0;
        e.ci = 1'b1;
        e.imm = b0;
      end
      AMD_DIR_L: e.ea = w;
      AMD_IDX_0: e.ea = {8'h00, ix};
      AMD_IDX_S: e.ea = 16'(b0) + 16'(ix);
      AMD_IDX_L: e.ea = w + 16'(ix);
      AMD_IND_S, AMD_BIT_I, AMD_BITR_I: e.ea = 16'(p[15:8]);
      AMD_IND_L: e.ea = p;
      AMD_INDX_S: e.ea = 16'(p[15:8]) + 16'(ix);
      AMD_INDX_L: e.ea = p + 16'(ix);
      default: e.ea = {8'h00, b0};
    endcase
    if (rmw && refused(m)) begin
      e = '0;
      e.ill = 1'b1;
    end else begin
      if (e.len != 2'h0) mem_i.ops.push_back(b0);
      if (e.len == 2'h2) mem_i.ops.push_back(b1);
    end
    expq.push_back(e);
    req.mode = m;
    req.use_y = y;
    req.rmw = rmw;
    req.idx_x = x;
    req.idx_y = yv;
    req.start = 1'b1;
    @(posedge i_sys_clk);
    #1 req.start = 1'b0;
    for (n = 0; n < 100 && res.done !== 1'b1; n++) begin
      @(posedge i_sys_clk);
      #1;
    end
    if (n == 100) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
      test_done();
    end
    @(posedge i_sys_clk);
    #1;
  endtask

  // Result watcher takes the oldest note on each done
  always @(posedge i_sys_clk) begin
    amd_exp_t e;
    if (res.done === 1'b1) begin
      if (expq.size() == 0) check(16'h0000, 16'h0001);
      else begin
        e = expq.pop_front();
        check(16'(res.illegal), 16'(e.ill));
        if (!e.ill) check(16'(res.len), 16'(e.len));
        if (!e.ill && e.ce) check(res.ea, e.ea);
        if (!e.ill && e.ci) check(16'(res.imm), 16'(e.imm));
      end
    end
  end

  initial begin
    i_rstn = 1'b0;
    slow = 1'b0;
    req = '0;
    for (int i = 0; i < 512; i++) mem_i.zp[i] = 8'($random(seed));
    repeat (3) @(posedge i_sys_clk);
    #1;
    check(16'({byte_req, mem_rd, busy, res.done, res.illegal}), 16'h0000);
    check(res.ea, AMD_ADDR_RST);
    i_rstn = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    $display("Test reset done");
    // Every mode, both index registers, prompt and slow memory
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      for (int m = 0; m < 17; m++)
        for (int y = 0; y < 2; y++)
          run_op(amd_mode_t'(m), y[0], 1'b0, 8'($random(seed)), 8'($random(seed)),
                 8'($random(seed)), 8'($random(seed)));
    end
    $display("Test all modes done");
    // Carry kept past page zero, index alone stays in page zero
    run_op(AMD_IDX_S, 1'b0, 1'b0, 8'hFF, 8'h00, 8'hFF, 8'h00);
    run_op(AMD_IDX_S, 1'b1, 1'b0, 8'h00, 8'hFF, 8'hFF, 8'h00);
    mem_i.zp[9'h040] = 8'hFF;
    run_op(AMD_INDX_S, 1'b1, 1'b0, 8'h00, 8'hFF, 8'h40, 8'h00);
    run_op(AMD_IDX_0, 1'b0, 1'b0, 8'hFF, 8'h00, 8'h00, 8'h00);
    run_op(AMD_IND_L, 1'b0, 1'b0, 8'h00, 8'h00, 8'hFF, 8'h00);
    $display("Test boundaries done");
    // Read-modify-write against every mode
    for (int m = 0; m < 17; m++)
      run_op(amd_mode_t'(m), 1'b0, 1'b1, 8'($random(seed)), 8'h00, 8'($random(seed)), 8'h00);
    $display("Test rmw done");
    test_done();
  end
endmodule
